// ===== design/psrw_pkg.sv
// Purpose: constants for the processor supervisor (reset stretch, watchdog)
// Assumes: 100 MHz clock, digital supply-low and comparator indications
// Notes:   times kept in their printed units, cycle counts derived here
package psrw_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned RESET_STRETCH_MS = 200;
  localparam int unsigned WD_TIMEOUT_MS    = 1600;
  localparam int unsigned MR_DEBOUNCE_NS   = 500;
  localparam int unsigned RESET_CYCLES     = RESET_STRETCH_MS * 1000 * CLK_MHZ;
  localparam int unsigned WD_CYCLES        = WD_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int unsigned DEBOUNCE_CYCLES  = (MR_DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W            = 32;
  localparam logic        RESET_N_INIT     = 1'b0;
  localparam logic        WDO_N_INIT       = 1'b1;
  localparam logic        PFW_N_INIT       = 1'b1;
  // synchroniser idle levels {float, kick, sense, push_n, supply_low}
  localparam logic [4:0]  SYNC_INIT        = 5'h06;
endpackage : psrw_pkg

// ===== design/psrw_supervisor.sv
// Purpose: reset generator, debounced manual reset, watchdog, power-fail flag
// Assumes: all inputs asynchronous to clock; float detect comes from a pad sensor
// Notes:   watchdog never drives the reset; tie its output to manual_push_n
//
// Behaviour
// - supply low asserts system reset
// - manual push low asserts system reset
// - reset stretched one period after causes clear
// - manual push input debounced against glitches
// - any kick edge restarts watchdog count
// - static kick too long drives timeout low
// - supply low holds timeout output low
// - active-high reset is exact complement
// - power-fail warning high while sense above
// - power-fail path independent of reset and watchdog logic
// - floating kick disables the watchdog
// - supply low holds watchdog stopped
`timescale 1ns/1ns
module psrw_supervisor
  import psrw_pkg::*;
#(
  parameter int unsigned RESET_CNT = RESET_CYCLES,
  parameter int unsigned WD_CNT    = WD_CYCLES,
  parameter int unsigned DEB_CNT   = DEBOUNCE_CYCLES
)(
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic supply_low,
  input  wire logic manual_push_n,
  input  wire logic watchdog_kick,
  input  wire logic kick_floating,
  input  wire logic power_fail_sense,
  output logic      sys_reset_n,
  output logic      sys_reset,
  output logic      watchdog_expired_n,
  output logic      power_fail_warn_n
);
  // refuse counts that the compare-at-limit-minus-one logic cannot serve
  if (RESET_CNT < 2 || WD_CNT < 2 || DEB_CNT < 1)
  begin : g_bad_counts
    $error("psrw_supervisor: counts too small");
  end

  // two-flop synchronisers; stage one is read only by stage two
  logic [4:0] s1_r, s2_r;
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      // idle levels, so neither a false kick edge nor a warning blip follows reset
      s1_r <= SYNC_INIT;
      s2_r <= SYNC_INIT;
    end
    else
    begin
      s1_r <= {kick_floating, watchdog_kick, power_fail_sense, manual_push_n, supply_low};
      s2_r <= s1_r;
    end
  end
  wire logic sup_low = s2_r[0];
  wire logic mr_s    = s2_r[1];
  wire logic pfs_s   = s2_r[2];
  wire logic kick_s  = s2_r[3];
  wire logic float_s = s2_r[4];

  // debounce: a level must hold for DEB_CNT cycles before it is believed
  logic [CNT_W-1:0] deb_r, deb_nxt;
  logic             mr_db_r, mr_db_nxt;
  always_comb
  begin
    deb_nxt   = deb_r;
    mr_db_nxt = mr_db_r;
    if (mr_s == mr_db_r)
      deb_nxt = '0;
    else if (deb_r >= CNT_W'(DEB_CNT - 1))
    begin
      mr_db_nxt = mr_s;
      deb_nxt   = '0;
    end
    else
      deb_nxt = deb_r + 1'b1;
  end

  // reset stretch counter restarts while any cause is active
  // the count only runs while the reset is low, so it stands still once released
  logic [CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;
  logic             rst_n_r, rst_n_nxt, rst_r, rst_nxt;
  wire logic        cause = sup_low | ~mr_db_r;
  always_comb
  begin
    rst_cnt_nxt = rst_cnt_r;
    rst_n_nxt   = rst_n_r;
    if (cause)
    begin
      rst_cnt_nxt = '0;
      rst_n_nxt   = 1'b0;
    end
    else if (!rst_n_r)
    begin
      if (rst_cnt_r >= CNT_W'(RESET_CNT - 1))
        rst_n_nxt = 1'b1;
      else
        rst_cnt_nxt = rst_cnt_r + 1'b1;
    end
    rst_nxt = ~rst_n_nxt;
  end

  // watchdog: only the kick edge, the float flag and the supply flag feed it, never the reset
  logic [CNT_W-1:0] wd_cnt_r, wd_cnt_nxt;
  logic             kick_d_r, wdo_n_r, wdo_n_nxt;
  wire logic        kick_edge = kick_s ^ kick_d_r;
  always_comb
  begin
    wd_cnt_nxt = wd_cnt_r;
    wdo_n_nxt  = wdo_n_r;
    if (sup_low)
    begin
      wd_cnt_nxt = '0;
      wdo_n_nxt  = 1'b0;
    end
    else if (float_s)
    begin
      wd_cnt_nxt = '0;
      wdo_n_nxt  = 1'b1;
    end
    else if (kick_edge)
    begin
      wd_cnt_nxt = '0;
      wdo_n_nxt  = 1'b1;
    end
    else if (wd_cnt_r >= CNT_W'(WD_CNT - 1))
      wdo_n_nxt = 1'b0;
    else
    begin
      // still inside the period, so the output stands high; this also lets it
      // recover by itself once the supply is valid again
      wd_cnt_nxt = wd_cnt_r + 1'b1;
      wdo_n_nxt  = 1'b1;
    end
  end

  // power-fail warning is a plain registered copy of the comparator
  // no term of the reset or watchdog state reaches it, by construction
  logic pfw_n_r, pfw_n_nxt;
  always_comb
  begin
    pfw_n_nxt = pfs_s;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      deb_r     <= '0;
      mr_db_r   <= 1'b1;
      rst_cnt_r <= '0;
      rst_n_r   <= RESET_N_INIT;
      rst_r     <= ~RESET_N_INIT;
      wd_cnt_r  <= '0;
      kick_d_r  <= 1'b0;
      wdo_n_r   <= WDO_N_INIT;
      pfw_n_r   <= PFW_N_INIT;
    end
    else
    begin
      deb_r     <= deb_nxt;
      mr_db_r   <= mr_db_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      rst_n_r   <= rst_n_nxt;
      rst_r     <= rst_nxt;
      wd_cnt_r  <= wd_cnt_nxt;
      kick_d_r  <= kick_s;
      wdo_n_r   <= wdo_n_nxt;
      pfw_n_r   <= pfw_n_nxt;
    end
  end

  // outputs come straight from their flip-flops, no logic after the register
  assign sys_reset_n        = rst_n_r;
  assign sys_reset          = rst_r;
  assign watchdog_expired_n = wdo_n_r;
  assign power_fail_warn_n  = pfw_n_r;

  // assertions; each watches what the logic drives, checked on the same edge or, for |=>, one edge later
  a_reset_on_supply: assert property (@(posedge clock) disable iff (!rstn)
    sup_low |=> !sys_reset_n) else $error("reset not asserted on supply low");
  a_reset_on_push: assert property (@(posedge clock) disable iff (!rstn)
    !mr_db_r |=> !sys_reset_n) else $error("reset not asserted on push");
  a_reset_stretch: assert property (@(posedge clock) disable iff (!rstn)
    $rose(sys_reset_n) |-> rst_cnt_r == CNT_W'(RESET_CNT - 1))
    else $error("reset released early");
  a_debounce_hold: assert property (@(posedge clock) disable iff (!rstn)
    $changed(mr_db_r) |-> $past(mr_s) == mr_db_r) else $error("debounce took bad level");
  a_kick_restart: assert property (@(posedge clock) disable iff (!rstn)
    kick_edge |=> wd_cnt_r == '0) else $error("kick did not restart");
  a_wd_timeout: assert property (@(posedge clock) disable iff (!rstn)
    $fell(watchdog_expired_n) && !$past(sup_low) |-> $past(wd_cnt_r) == CNT_W'(WD_CNT - 1))
    else $error("timeout at wrong count");
  a_wdo_supply: assert property (@(posedge clock) disable iff (!rstn)
    sup_low |=> !watchdog_expired_n && wd_cnt_r == '0)
    else $error("watchdog active in supply low");
  // a timeout alone must never pull the reset low; only a cause may
  a_wd_no_reset: assert property (@(posedge clock) disable iff (!rstn)
    $fell(sys_reset_n) |-> $past(cause)) else $error("reset fell without a cause");
  a_complement: assert property (@(posedge clock) disable iff (!rstn)
    sys_reset == !sys_reset_n) else $error("reset outputs not complementary");
  a_pfw_follow: assert property (@(posedge clock) disable iff (!rstn)
    1'b1 |=> power_fail_warn_n == $past(pfs_s)) else $error("power-fail mismatch");
  a_float_off: assert property (@(posedge clock) disable iff (!rstn)
    float_s && !sup_low |=> watchdog_expired_n) else $error("floating kick timed out");
  // the compare-at-limit logic relies on the counters never passing the limit
  a_wd_bound: assert property (@(posedge clock) disable iff (!rstn)
    wd_cnt_r <= CNT_W'(WD_CNT - 1)) else $error("watchdog count overran");
  a_stretch_bound: assert property (@(posedge clock) disable iff (!rstn)
    rst_cnt_r <= CNT_W'(RESET_CNT - 1)) else $error("stretch count overran");
  // main scenarios: release, expiry, push, power-fail, supply recovery
  c_reset_release: cover property (@(posedge clock) disable iff (!rstn) $rose(sys_reset_n));
  c_wd_expire: cover property (@(posedge clock) disable iff (!rstn)
    $fell(watchdog_expired_n) && !sup_low);
  c_push: cover property (@(posedge clock) disable iff (!rstn) $fell(mr_db_r));
  c_pfw: cover property (@(posedge clock) disable iff (!rstn) $fell(power_fail_warn_n));
  c_supply_back: cover property (@(posedge clock) disable iff (!rstn) $fell(sup_low));
endmodule : psrw_supervisor

// ===== verification/psrw_host.sv
// Purpose: host model that kicks the watchdog pin
// Assumes: kick toggles every gap+1 cycles while en is high
// Notes:   dropping en starves the watchdog on purpose
`timescale 1ns/1ns
module psrw_host (
  input  wire logic       clock,
  input  wire logic       en,
  input  wire logic [7:0] gap,
  output logic            kick
);
  logic [7:0] cnt_r = 8'h00;
  initial kick = 1'b0;
  // level held many cycles so the synchroniser never misses an edge
  always @(negedge clock)
  begin
    cnt_r <= (en && cnt_r < gap) ? cnt_r + 8'h01 : 8'h00;
    if (en && cnt_r == gap) kick <= ~kick;
  end
endmodule : psrw_host

// ===== verification/tb.sv
// Purpose: self-checking bench for the supervisor
// Assumes: short sim counts, inputs driven on the falling edge
// Notes:   output changes are matched against queued notes
`timescale 1ns/1ns
module tb;
  import psrw_pkg::*;
  localparam int RC = 20;
  localparam int WC = 40;
  localparam int LIMIT_NS = 10 * (8 * RC + 4 * WC + 400); // about twice the scenario length
  logic clock = 0, rstn = 0, supply_low = 0, push_n = 1, flt = 0, pfs = 1, hen = 1;
  logic kick, srn, sr, wdo_n, pfw_n;
  logic [31:0] lfsr = 32'hd49b;
  int num_errors = 0;
  int checks_done = 0;
  time t_rel = 0;
  bit go = 0;
  logic [7:0] kick_gap;
  int stretch_min = RC - 1; // the first edge out of reset already counts
  logic qr[$], qw[$], qp[$];
  always #5 clock = ~clock;
  psrw_host host (.clock(clock), .en(hen), .gap(kick_gap), .kick(kick));
  psrw_supervisor #(.RESET_CNT(RC), .WD_CNT(WC), .DEB_CNT(3)) uut (
    .clock(clock), .rstn(rstn), .supply_low(supply_low), .manual_push_n(push_n),
    .watchdog_kick(kick), .kick_floating(flt), .power_fail_sense(pfs),
    .sys_reset_n(srn), .sys_reset(sr), .watchdog_expired_n(wdo_n),
    .power_fail_warn_n(pfw_n));
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin num_errors++; $display("unexpected at %0t: exp %h got %h", $time, e, g); end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  // 32-bit shift register for the random stimulus
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  // random sense level; a change is noted before it is driven
  task automatic pf;
    lfsr = lfsr_next(lfsr);
    if (lfsr[0] !== pfs) qp.push_back(lfsr[0]);
    pfs = lfsr[0];
  endtask : pf
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // watchers: each output change takes the oldest note
  always @(srn) if (go) cmp(qr.size() ? qr.pop_front() : 1'bx, srn);
  always @(wdo_n) if (go) cmp(qw.size() ? qw.pop_front() : 1'bx, wdo_n);
  always @(pfw_n) if (go) cmp(qp.size() ? qp.pop_front() : 1'bx, pfw_n);
  // stretch measured from the last cause release, in whole clock periods
  always @(posedge srn)
    if (go) cmp((($time - t_rel) / 10) inside {[stretch_min : RC + 8]}, 1);
  // looked at mid-cycle, away from the edge that launches both outputs
  always @(negedge clock) if (go) cmp(sr, !srn);
  initial
  begin
    #(LIMIT_NS);
    num_errors++;
    tally_and_finish;
  end
  initial
  begin
    lfsr = lfsr_next(lfsr);
    kick_gap = 8'h09 + {4'h0, lfsr[3:0]};
    cyc(2);
    go = 1;
    qr.push_back(1);
    cyc(10);
    rstn = 1;
    t_rel = $time;
    cyc(RC + 15);
    $display("power-up done");
    stretch_min = RC;
    qr.push_back(0);
    qw.push_back(0);
    supply_low = 1;
    cyc(8);
    pf;
    cyc(12);
    qr.push_back(1);
    qw.push_back(1);
    supply_low = 0;
    t_rel = $time;
    cyc(RC + 15);
    $display("supply low done");
    push_n = 0;
    cyc(1 + int'(lfsr[1])); // one or two cycles, both under the debounce time
    push_n = 1;
    cyc(10);
    qr.push_back(0);
    push_n = 0;
    pf;
    cyc(12);
    qr.push_back(1);
    push_n = 1;
    t_rel = $time;
    cyc(RC + 15);
    $display("manual push done");
    hen = 0;
    qw.push_back(0);
    cyc(WC + 15);
    qw.push_back(1);
    hen = 1;
    cyc(WC); // longest kick gap plus sync latency stays under this
    $display("watchdog done");
    flt = 1;
    hen = 0;
    cyc(WC + 20);
    hen = 1;
    flt = 0;
    repeat (8)
    begin
      pf;
      cyc(4);
    end
    $display("float and power-fail done");
    cyc(10);
    cmp(qr.size() + qw.size() + qp.size(), 0);
    tally_and_finish;
  end
endmodule : tb
